// ==== inc/iocn_pkg.sv ====
// package for the i/o port with change notification: offsets, reset values, bus carrier
// assumes a 16-bit register port clocked by the instruction clock
package iocn_pkg;

  localparam int IOCN_DW = 16;
  localparam int IOCN_AW = 4;
  localparam int IOCN_PINS = 16;
  localparam int IOCN_CN_NUM = 31;
  localparam int IOCN_CN_LO_W = 16;

  // register word offsets
  localparam logic [3:0] IOCN_OFS_DIR = 4'h0;
  localparam logic [3:0] IOCN_OFS_PORT = 4'h1;
  localparam logic [3:0] IOCN_OFS_LATCH = 4'h2;
  localparam logic [3:0] IOCN_OFS_ODC = 4'h3;
  localparam logic [3:0] IOCN_OFS_APCFG = 4'h4;
  localparam logic [3:0] IOCN_OFS_CNEN_LO = 4'h5;
  localparam logic [3:0] IOCN_OFS_CNEN_HI = 4'h6;
  localparam logic [3:0] IOCN_OFS_CNPU_LO = 4'h7;
  localparam logic [3:0] IOCN_OFS_CNPU_HI = 4'h8;
  localparam logic [3:0] IOCN_OFS_STATUS = 4'h9;
  localparam logic [3:0] IOCN_OFS_MASK = 4'ha;

  // reset values
  localparam logic [15:0] IOCN_RST_DIR = 16'hffff;
  localparam logic [15:0] IOCN_RST_LATCH = 16'h0000;
  localparam logic [15:0] IOCN_RST_ODC = 16'h0000;
  localparam logic [15:0] IOCN_RST_APCFG = 16'h0000;
  localparam logic [15:0] IOCN_RST_CNEN = 16'h0000;
  localparam logic [15:0] IOCN_RST_CNPU = 16'h0000;
  localparam logic [15:0] IOCN_RST_STATUS = 16'h0000;
  localparam logic [15:0] IOCN_RST_MASK = 16'h0000;

  // status and mask field positions
  localparam int IOCN_STAT_CN_BIT = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } iocn_bus_req_type;

endpackage

// ==== design/iocn_port.sv ====
// i/o port with open-drain, analog configuration and change notification
// assumes pins and notification inputs are asynchronous; registers on a one-cycle port
// wake output is the only combinational output; it feeds wake logic, never flops
//
// Overview of operation
// RULE1: open-drain bit set makes the pin drive low only, releasing for high.
// RULE2: analog configuration resets to zero, so shared pins start analog.
// RULE3: reading the port returns zero for every pin in analog mode.
// RULE4: software keeps analog pins as inputs, else the driven level is converted.
// RULE5: digital-mode pins are never routed to the converter.
// RULE6: software waits one cycle between a port write and a read; here a read returns a newly driven level only after three idle cycles.
// RULE7: port reads sample the synchronised pin level, never the output latch.
// RULE8: an enabled notification input changing state raises the interrupt; here it sets the status flag, and IRQ_OUT rises only while mask bit 0 is set.
// RULE9: a clockless compare path flags changes while clocks are stopped.
// RULE10: up to 31 notification inputs, count set by a parameter.
// RULE11: two enable registers hold one interrupt enable per notification input.
// RULE12: two pull-up registers hold one weak pull-up enable per input.
// RULE13: software turns pull-ups off on pins used as digital outputs.
// RULE14: enabled mismatches against captured levels OR into one sticky flag.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module iocn_port #(
  parameter int PINS = iocn_pkg::IOCN_PINS,
  parameter int CN_NUM = iocn_pkg::IOCN_CN_NUM
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire iocn_pkg::iocn_bus_req_type BUS_IN,
  output logic [15:0] RDATA_OUT,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PIN_OUT,
  output logic [PINS-1:0] PIN_OE_OUT,
  output logic [PINS-1:0] ANALOG_ROUTE_OUT,
  input wire logic [CN_NUM-1:0] CN_IN,
  output logic [CN_NUM-1:0] PULLUP_OUT,
  output logic IRQ_OUT,
  output logic WAKE_OUT
);
  import iocn_pkg::*;

  // pads a pin vector to the register width
  function automatic logic [15:0] zext(input logic [PINS-1:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < PINS; i++) begin
      r[i] = v[i];
    end
    return r;
  endfunction

  // the high half only keeps bits that have an input behind them
  function automatic logic [15:0] hi_mask();
    logic [15:0] r;
    r = 16'h0000;
    for (int i = IOCN_CN_LO_W; i < CN_NUM; i++) begin
      r[i-IOCN_CN_LO_W] = 1'b1;
    end
    return r;
  endfunction

  // glues the two register halves into one vector ordered by input number
  function automatic logic [CN_NUM-1:0] join_cn(input logic [15:0] lo, input logic [15:0] hi);
    logic [CN_NUM-1:0] r;
    r = '0;
    for (int i = 0; i < CN_NUM; i++) begin
      if (i < IOCN_CN_LO_W) begin
        r[i] = lo[i];
      end else begin
        r[i] = hi[i-IOCN_CN_LO_W];
      end
    end
    return r;
  endfunction

  // open drain never drives a high: a set latch leaves the level to the pull-up
  function automatic logic [PINS-1:0] drive_level(input logic [PINS-1:0] lat,
    input logic [PINS-1:0] od);
    return lat & ~od;
  endfunction

  // an open-drain pin is released when its latch is high
  function automatic logic [PINS-1:0] drive_enable(input logic [PINS-1:0] dir,
    input logic [PINS-1:0] lat, input logic [PINS-1:0] od);
    return ~dir & (~od | ~lat);
  endfunction

  localparam logic [15:0] CN_HI_MASK = hi_mask();

  logic [PINS-1:0] dir_q;
  logic [PINS-1:0] latch_q;
  logic [PINS-1:0] odc_q;
  logic [PINS-1:0] apcfg_q;
  logic [15:0] cnen_lo_q;
  logic [15:0] cnen_hi_q;
  logic [15:0] cnpu_lo_q;
  logic [15:0] cnpu_hi_q;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] mask_q;
  logic [15:0] rdata_q;
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic [CN_NUM-1:0] cn_meta_q;
  logic [CN_NUM-1:0] cn_sync_q;
  logic [CN_NUM-1:0] cn_ref_q;
  logic ref_valid_q;
  logic [PINS-1:0] pin_out_q;
  logic [PINS-1:0] pin_oe_q;
  logic [PINS-1:0] route_q;
  logic [CN_NUM-1:0] pullup_q;
  logic irq_q;
  logic [CN_NUM-1:0] cn_en;
  logic cn_change;
  logic wr_hit;
  logic rd_hit;
  logic [CN_NUM-1:0] cn_diff;
  logic stat_clr;

  assign wr_hit = BUS_IN.wr;
  assign rd_hit = BUS_IN.rd;
  assign cn_en = join_cn(cnen_lo_q, cnen_hi_q); // [RULE11]

  // pin configuration registers
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      dir_q <= IOCN_RST_DIR[PINS-1:0];
      latch_q <= IOCN_RST_LATCH[PINS-1:0];
      odc_q <= IOCN_RST_ODC[PINS-1:0];
      apcfg_q <= IOCN_RST_APCFG[PINS-1:0]; // [RULE2]
    end else if (CE_IN && wr_hit) begin
      case (BUS_IN.addr)
        IOCN_OFS_DIR: begin
          dir_q <= BUS_IN.wdata[PINS-1:0];
        end
        // a port write lands in the latch; the pin follows a cycle later
        IOCN_OFS_PORT, IOCN_OFS_LATCH: begin
          latch_q <= BUS_IN.wdata[PINS-1:0];
        end
        IOCN_OFS_ODC: begin
          odc_q <= BUS_IN.wdata[PINS-1:0]; // [RULE1]
        end
        IOCN_OFS_APCFG: begin
          apcfg_q <= BUS_IN.wdata[PINS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // notification enables and pull-ups; unused high bits store zero
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      cnen_lo_q <= IOCN_RST_CNEN;
      cnen_hi_q <= IOCN_RST_CNEN;
      cnpu_lo_q <= IOCN_RST_CNPU;
      cnpu_hi_q <= IOCN_RST_CNPU;
    end else if (CE_IN && wr_hit) begin
      case (BUS_IN.addr)
        IOCN_OFS_CNEN_LO: begin
          cnen_lo_q <= BUS_IN.wdata; // [RULE11]
        end
        IOCN_OFS_CNEN_HI: begin
          cnen_hi_q <= BUS_IN.wdata & CN_HI_MASK; // [RULE10] [RULE11]
        end
        IOCN_OFS_CNPU_LO: begin
          cnpu_lo_q <= BUS_IN.wdata; // [RULE12]
        end
        IOCN_OFS_CNPU_HI: begin
          cnpu_hi_q <= BUS_IN.wdata & CN_HI_MASK; // [RULE12]
        end
        default: begin
        end
      endcase
    end
  end

  // interrupt mask: only the change flag has a mask bit
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      mask_q <= IOCN_RST_MASK;
    end else if (CE_IN && wr_hit && BUS_IN.addr == IOCN_OFS_MASK) begin
      mask_q <= BUS_IN.wdata & 16'h0001;
    end
  end

  // two-flop synchroniser for the port pins
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (CE_IN) begin
      pin_meta_q <= PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  // two-flop synchroniser for the notification inputs
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      cn_meta_q <= '0;
      cn_sync_q <= '0;
    end else if (CE_IN) begin
      cn_meta_q <= CN_IN;
      cn_sync_q <= cn_meta_q;
    end
  end

  // pin drivers and converter routing
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      route_q <= '0;
    end else if (CE_IN) begin
      pin_out_q <= drive_level(latch_q, odc_q); // [RULE1]
      pin_oe_q <= drive_enable(dir_q, latch_q, odc_q); // [RULE1]
      // routing ignores direction; an output pin converts its own level
      route_q <= ~apcfg_q; // [RULE5] [RULE4]
    end
  end

  // pull-ups follow their registers even on outputs; software must drop them
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      pullup_q <= '0;
    end else if (CE_IN) begin
      pullup_q <= join_cn(cnpu_lo_q, cnpu_hi_q); // [RULE12]
    end
  end

  // captured levels; the first cycle after reset only primes the reference
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      cn_ref_q <= '0;
      ref_valid_q <= 1'b0;
    end else if (CE_IN) begin
      // reference follows the synchroniser so a held level never fires twice
      cn_ref_q <= cn_sync_q;
      ref_valid_q <= 1'b1;
    end
  end

  // a mismatch on any enabled input counts; which one it was is not kept
  assign cn_diff = (cn_sync_q ^ cn_ref_q) & cn_en; // [RULE14]
  assign cn_change = ref_valid_q && (|cn_diff); // [RULE8]
  assign stat_clr = rd_hit && (BUS_IN.addr == IOCN_OFS_STATUS);

  always_comb begin
    status_d = status_q;
    if (stat_clr) begin
      status_d = 16'h0000;
    end
    // a change in the clearing cycle still sets the flag
    if (cn_change) begin
      status_d[IOCN_STAT_CN_BIT] = 1'b1; // [RULE14]
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      status_q <= IOCN_RST_STATUS;
    end else if (CE_IN) begin
      status_q <= status_d;
    end
  end

  // irq is taken from the next status so it rises with the flag, not after it
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      irq_q <= 1'b0;
    end else if (CE_IN) begin
      irq_q <= |(status_d & mask_q); // [RULE8]
    end
  end

  // read data stands one cycle only; unmapped offsets read zero
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 16'h0000;
    end else if (CE_IN) begin
      rdata_q <= 16'h0000;
      if (rd_hit) begin
        case (BUS_IN.addr)
          IOCN_OFS_DIR: begin
            rdata_q <= zext(dir_q);
          end
          // pin level two cycles stale, hence the software gap after writes
          IOCN_OFS_PORT: begin
            rdata_q <= zext(pin_sync_q & apcfg_q); // [RULE7] [RULE3] [RULE6]
          end
          IOCN_OFS_LATCH: begin
            rdata_q <= zext(latch_q);
          end
          IOCN_OFS_ODC: begin
            rdata_q <= zext(odc_q);
          end
          IOCN_OFS_APCFG: begin
            rdata_q <= zext(apcfg_q);
          end
          IOCN_OFS_CNEN_LO: begin
            rdata_q <= cnen_lo_q;
          end
          IOCN_OFS_CNEN_HI: begin
            rdata_q <= cnen_hi_q;
          end
          IOCN_OFS_CNPU_LO: begin
            rdata_q <= cnpu_lo_q;
          end
          IOCN_OFS_CNPU_HI: begin
            rdata_q <= cnpu_hi_q;
          end
          // returns the flag as it stood before this cycle's clear
          IOCN_OFS_STATUS: begin
            rdata_q <= status_q;
          end
          IOCN_OFS_MASK: begin
            rdata_q <= mask_q;
          end
          default: begin
            rdata_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign RDATA_OUT = rdata_q;
  assign PIN_OUT = pin_out_q;
  assign PIN_OE_OUT = pin_oe_q;
  assign ANALOG_ROUTE_OUT = route_q;
  assign PULLUP_OUT = pullup_q;
  assign IRQ_OUT = irq_q;
  // wake path compares raw inputs with no clock so it works in sleep;
  // it may glitch and must only be used as an asynchronous wake request
  assign WAKE_OUT = |((CN_IN ^ cn_ref_q) & cn_en); // [RULE9]

endmodule

`default_nettype wire

// ==== bench/iocn_port_monitor.sv ====
// checker: bus answers, pin drive, routing, pull-ups, interrupt mask
// assumes the clock enable is high whenever a checked register is written
`timescale 1ns/1ps
`default_nettype none
module iocn_port_monitor
  import iocn_pkg::*;
#(
  parameter int PINS = 16,
  parameter int CN_NUM = 31
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire iocn_bus_req_type BUS_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic [PINS-1:0] PIN_OUT,
  input wire logic [PINS-1:0] PIN_OE_OUT,
  input wire logic [PINS-1:0] ANALOG_ROUTE_OUT,
  input wire logic [CN_NUM-1:0] PULLUP_OUT,
  input wire logic IRQ_OUT,
  input wire logic WAKE_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  wire logic wr = BUS_IN.wr;
  wire logic rd = BUS_IN.rd;
  wire logic [3:0] ad = BUS_IN.addr;
  wire logic [15:0] wd = BUS_IN.wdata;
  a_read_one_cycle: assert property (!rd |=> RDATA_OUT == 16'h0000)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (rd && ad > IOCN_OFS_MASK |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  a_route_reset: assert property ($rose(RST_N_IN) |=> &ANALOG_ROUTE_OUT)
    else $error("pins not analog after reset");
  a_analog_low: assert property (rd && ad == IOCN_OFS_PORT |=>
    (RDATA_OUT[PINS-1:0] & ANALOG_ROUTE_OUT) == '0)
    else $error("analog pin read high");
  a_od_no_high: assert property (wr && ad == IOCN_OFS_ODC |->
    ##2 (PIN_OUT & $past(wd, 2)) == '0)
    else $error("open-drain pin driven high");
  a_inputs_float: assert property (wr && ad == IOCN_OFS_DIR |->
    ##2 (PIN_OE_OUT & $past(wd, 2)) == '0)
    else $error("input pin driven");
  a_route_cfg: assert property (wr && ad == IOCN_OFS_APCFG |->
    ##2 ANALOG_ROUTE_OUT == ~$past(wd, 2))
    else $error("routing differs from config");
  a_pullup_set: assert property (wr && ad == IOCN_OFS_CNPU_LO |->
    ##2 PULLUP_OUT[15:0] == $past(wd, 2))
    else $error("pull-up enables differ");
  a_mask_quiet: assert property (wr && ad == IOCN_OFS_MASK && !wd[0] |-> ##2 !IRQ_OUT)
    else $error("masked interrupt high");
  c_irq: cover property ($rose(IRQ_OUT));
  c_wake: cover property (WAKE_OUT);
  c_port_rd: cover property (rd && ad == IOCN_OFS_PORT);
endmodule
bind iocn_port iocn_port_monitor #(.PINS(PINS), .CN_NUM(CN_NUM)) mon (.MCLK_IN(MCLK_IN),
  .RST_N_IN(RST_N_IN), .BUS_IN(BUS_IN), .RDATA_OUT(RDATA_OUT), .PIN_OUT(PIN_OUT),
  .PIN_OE_OUT(PIN_OE_OUT), .ANALOG_ROUTE_OUT(ANALOG_ROUTE_OUT), .PULLUP_OUT(PULLUP_OUT),
  .IRQ_OUT(IRQ_OUT), .WAKE_OUT(WAKE_OUT));
`default_nettype wire

// ==== bench/iocn_pins_model.sv ====
// pin and button model: resistive drivers on port pins, buttons to ground on notify inputs
// assumes the port drives its pins harder than the external resistors
`timescale 1ns/1ps
`default_nettype none
module iocn_pins_model (
  input wire logic clk_in,
  input wire logic [15:0] out_in,
  input wire logic [15:0] oe_in,
  input wire logic [15:0] ext_in,
  input wire logic [30:0] pullup_in,
  input wire logic [30:0] press_in,
  output logic [15:0] pin_out,
  output logic [30:0] cn_out
);
  logic [30:0] float_q = '0;
  // an unpulled released input has no level: show one that moves every cycle
  always @(posedge clk_in) begin
    float_q <= ~cn_out;
  end
  // the port's own driver wins over the resistor
  assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
  // pressed pulls low, released floats unless the weak pull-up is on
  assign cn_out = ~press_in & (pullup_in | float_q);
endmodule
`default_nettype wire

// ==== bench/iocn_port_tb_top.sv ====
// testbench for the i/o port: register tasks, pin and button model, checks
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module iocn_port_tb_top;
  import iocn_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  iocn_bus_req_type bus = '0;
  logic [15:0] rdata, pout, poe, route, plvl;
  logic [15:0] ext = 16'h0000;
  logic [30:0] pu, cn;
  logic [30:0] press = '0;
  logic irq, wake;
  int err_count = 0;
  int samples_checked = 0;
  initial forever #2.5 clk = ~clk;
  iocn_port uut (.MCLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .BUS_IN(bus),
    .RDATA_OUT(rdata), .PIN_IN(plvl), .PIN_OUT(pout), .PIN_OE_OUT(poe),
    .ANALOG_ROUTE_OUT(route), .CN_IN(cn), .PULLUP_OUT(pu), .IRQ_OUT(irq), .WAKE_OUT(wake));
  iocn_pins_model pm (.clk_in(clk), .out_in(pout), .oe_in(poe), .ext_in(ext),
    .pullup_in(pu), .press_in(press), .pin_out(plvl), .cn_out(cn));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int id);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: check %0d got %h expected %h", $time, id, g, e);
    end
  endtask
  // both tasks start and end on a rising edge, so strobes never clash
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    bus <= '0;
    #1;
    chk({16'h0000, rdata}, {16'h0000, e}, int'(a));
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(IOCN_OFS_DIR, 16'hffff);
    rc(IOCN_OFS_APCFG, 16'h0000);
    rc(IOCN_OFS_CNEN_HI, 16'h0000);
    rc(IOCN_OFS_CNPU_LO, 16'h0000);
    rc(4'hc, 16'h0000);
    chk({31'h0, wake}, 32'h0, 14);
    ext <= 16'ha5a5;
    rc(IOCN_OFS_PORT, 16'h0000);
    chk({16'h0000, route}, 32'h0000ffff, 1);
    wr(IOCN_OFS_APCFG, 16'h00ff);
    // analog pins stay inputs
    wr(IOCN_OFS_DIR, 16'hfff0);
    wr(IOCN_OFS_ODC, 16'h000f);
    wr(IOCN_OFS_LATCH, 16'h000f);
    // wait out the port read delay
    repeat (4) @(posedge clk);
    chk({16'h0000, route}, 32'h0000ff00, 2);
    chk({poe, pout}, 32'h00000000, 3);
    rc(IOCN_OFS_PORT, 16'h00a5);
    rc(IOCN_OFS_LATCH, 16'h000f);
    wr(IOCN_OFS_LATCH, 16'h000a);
    repeat (4) @(posedge clk);
    chk({poe, pout}, 32'h00050000, 4);
    rc(IOCN_OFS_PORT, 16'h00a0);
    wr(IOCN_OFS_ODC, 16'h0000);
    repeat (4) @(posedge clk);
    chk({poe, pout}, 32'h000f000a, 5);
    rc(IOCN_OFS_PORT, 16'h00aa);
    // pull-ups only on notify inputs, never on driven outputs
    wr(IOCN_OFS_CNPU_LO, 16'h0003);
    wr(IOCN_OFS_CNPU_HI, 16'hc000);
    wr(IOCN_OFS_CNEN_LO, 16'h0001);
    wr(IOCN_OFS_CNEN_HI, 16'h4000);
    wr(IOCN_OFS_MASK, 16'hffff);
    rc(IOCN_OFS_MASK, 16'h0001);
    repeat (4) @(posedge clk);
    chk({1'b0, pu}, 32'h40000003, 6);
    rc(IOCN_OFS_STATUS, 16'h0000);
    press <= 31'h00000002;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h0, 7);
    press <= 31'h00000003;
    #1;
    chk({31'h0, wake}, 32'h1, 8);
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1, 9);
    rc(IOCN_OFS_STATUS, 16'h0001);
    chk({31'h0, irq}, 32'h0, 10);
    rc(IOCN_OFS_STATUS, 16'h0000);
    press <= 31'h40000003;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1, 11);
    rc(IOCN_OFS_STATUS, 16'h0001);
    wr(IOCN_OFS_MASK, 16'h0000);
    press <= '0;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h0, 12);
    rc(IOCN_OFS_STATUS, 16'h0001);
    // with the clock enable low a write must not land
    ce <= 1'b0;
    wr(IOCN_OFS_LATCH, 16'h0005);
    ce <= 1'b1;
    rc(IOCN_OFS_LATCH, 16'h000a);
    chk({poe, pout}, 32'h000f000a, 13);
    complete_run;
  end
endmodule
`default_nettype wire
